// ---- verilog/ssfa_top.sv ----
// Frame aligner path top: word aligner, byte ordering, APB registers
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps

module ssfa_top (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          align_pattern_size_select,
    input  wire logic [ssfa_pkg::LANE_W-1:0]   rx_lane_data,
    output logic [ssfa_pkg::FABRIC_W-1:0]      rx_fabric_data,
    output logic                               rx_fabric_valid,
    output logic                               rx_sync_status,
    input  wire logic [ssfa_pkg::FABRIC_W-1:0] tx_fabric_data,
    output logic                               tx_fabric_ready,
    output logic [ssfa_pkg::LANE_W-1:0]        tx_lane_data
);
    import ssfa_pkg::*;

    // =====================================================================
    // Register bus
    // =====================================================================
    ssfa_mode_type   mode_q;
    logic            tx_flip_q;
    logic            rx_flip_q;
    logic            align_flip_q;
    logic            align_en_q;
    logic            pad_ovr_q;
    logic [7:0]      pad_byte_q;
    logic [15:0]     pattern_q;
    logic            pad_event_q;
    logic            sync_q;
    logic            shift_q;
    logic [3:0]      off_q;
    logic            wr_en;
    logic            pad_event_set;
    logic [31:0]     ctrl_view;

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;

    assign ctrl_view = {16'h0000, pad_byte_q, 1'b0, pad_ovr_q, align_en_q,
                        align_flip_q, rx_flip_q, tx_flip_q, mode_q};

    // Read mux and error flag
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            CTRL_OFFSET:    prdata = ctrl_view;
            PATTERN_OFFSET: prdata = {16'h0000, pattern_q};
            STATUS_OFFSET: begin
                prdata[STAT_SYNC_BIT]            = sync_q;
                prdata[STAT_SHIFT_BIT]           = shift_q;
                prdata[STAT_OFF_LSB +: 4]        = off_q;
                prdata[STAT_PADEV_BIT]           = pad_event_q;
            end
            default:        pslverr = psel && penable;
        endcase
    end

    // Control register; reset selects MSB-first with all three flips on
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q       <= MODE_RESET;
            tx_flip_q    <= 1'b1;
            rx_flip_q    <= 1'b1;
            align_flip_q <= 1'b1;
            align_en_q   <= 1'b0;
            pad_ovr_q    <= 1'b0;
            pad_byte_q   <= FRAME_FIRST_BYTE;
        end else if (wr_en && paddr == CTRL_OFFSET) begin
            // Code 3 is not a mode and falls back to OC-12
            mode_q       <= (pwdata[CTRL_MODE_LSB +: 2] == 2'b11) ? SSFA_OC12
                          : ssfa_mode_type'(pwdata[CTRL_MODE_LSB +: 2]);
            tx_flip_q    <= pwdata[CTRL_TXFLIP_BIT];
            rx_flip_q    <= pwdata[CTRL_RXFLIP_BIT];
            align_flip_q <= pwdata[CTRL_AFLIP_BIT];
            align_en_q   <= pwdata[CTRL_ALIGN_BIT];
            pad_ovr_q    <= pwdata[CTRL_PADOVR_BIT];
            pad_byte_q   <= pwdata[CTRL_PAD_LSB +: 8];
        end
    end

    // Programmed alignment pattern
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pattern_q <= PATTERN_RESET;
        end else if (wr_en && paddr == PATTERN_OFFSET) begin
            pattern_q <= pwdata[15:0];
        end
    end

    // Sticky pad-inserted flag, write one to clear; a new event wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pad_event_q <= 1'b0;
        end else if (pad_event_set) begin
            pad_event_q <= 1'b1;
        end else if (wr_en && paddr == STATUS_OFFSET && pwdata[STAT_PADEV_BIT]) begin
            pad_event_q <= 1'b0;
        end
    end

    // =====================================================================
    // Word aligner
    // =====================================================================
    logic [HIST_W-1:0] hist_q;
    logic [15:0]       cmp16;
    logic [31:0]       cmp32;
    logic              use32;
    logic [15:0]       hit;
    logic              match;
    logic [3:0]        match_off;
    logic [3:0]        max_off;
    logic [15:0]       aligned;

    // Earliest serial bit sits at bit 0; OC-12 and OC-48 lanes carry one byte
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hist_q <= 64'h0000_0000_0000_0000;
        end else if (mode_q == SSFA_OC96) begin
            hist_q <= {rx_lane_data, hist_q[HIST_W-1:16]};
        end else begin
            hist_q <= {rx_lane_data[7:0], hist_q[HIST_W-1:8]};
        end
    end

    // Compare pattern in serial order, optionally bit-reversed
    assign cmp16   = align_flip_q ? ssfa_rev16(pattern_q) : pattern_q;
    assign cmp32   = {cmp16[15:8], cmp16[15:8], cmp16[7:0], cmp16[7:0]};
    assign use32   = (mode_q == SSFA_OC96) || align_pattern_size_select;
    assign max_off = (mode_q == SSFA_OC96) ? 4'hF : 4'h7;

    // One comparator per bit offset of the lane word
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_off
            assign hit[g] = use32 ? (hist_q[g +: 32] == cmp32)
                                  : (hist_q[g +: 16] == cmp16);
        end
    endgenerate

    // Lowest matching offset wins
    always_comb begin
        match     = 1'b0;
        match_off = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (hit[i] && 4'(i) <= max_off) begin
                match     = 1'b1;
                match_off = 4'(i);
            end
        end
    end

    // Manual alignment: lock on the first match while enabled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= 1'b0;
            off_q  <= 4'h0;
        end else if (!align_en_q) begin
            sync_q <= 1'b0;
        end else if (!sync_q && match) begin
            sync_q <= 1'b1;
            off_q  <= match_off;
        end
    end

    assign rx_sync_status = sync_q;
    assign aligned = rx_flip_q ? ssfa_flip_bytes16(hist_q[off_q +: 16])
                               : hist_q[off_q +: 16];

    // =====================================================================
    // Byte ordering (OC-48)
    // =====================================================================
    logic        sync_prev_q;
    logic        pend_q;
    logic        insert_q;
    logic [15:0] dly_q;
    logic [15:0] feed;
    logic [7:0]  pad;
    logic [31:0] deser_word;
    logic        deser_valid;
    logic        sync_rise;
    logic        mismatch;

    assign sync_rise = sync_q && !sync_prev_q;
    assign mismatch  = deser_valid && pend_q && (deser_word[7:0] != FRAME_SECOND_BYTE);
    assign pad       = pad_ovr_q ? pad_byte_q : FRAME_FIRST_BYTE;
    assign pad_event_set = insert_q;

    // Arm one check per sync rising edge; a new edge wins over the clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev_q <= 1'b0;
            pend_q      <= 1'b0;
        end else begin
            sync_prev_q <= sync_q;
            if (sync_rise && mode_q == SSFA_OC48) begin
                pend_q <= 1'b1;
            end else if (deser_valid) begin
                pend_q <= 1'b0;
            end
        end
    end

    // Single pad insertion per armed check; each insertion toggles the one-byte slip (shift_q)
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            insert_q <= 1'b0;
            shift_q  <= 1'b0;
            dly_q    <= 16'h0000;
        end else begin
            insert_q <= mismatch && mode_q == SSFA_OC48;
            dly_q    <= aligned;
            if (mode_q != SSFA_OC48) begin
                shift_q <= 1'b0;
            end else if (insert_q) begin
                shift_q <= !shift_q;
            end
        end
    end

    // Deserializer input: pad, delayed or direct aligned data
    assign feed = insert_q ? {8'h00, pad} : (shift_q ? dly_q : aligned);

    ssfa_byte_deser u_deser (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .mode       (mode_q),
        .lane_data  (feed),
        .word_data  (deser_word),
        .word_valid (deser_valid)
    );

    assign rx_fabric_data  = deser_word;
    assign rx_fabric_valid = deser_valid;

    // =====================================================================
    // Transmit path
    // =====================================================================
    logic [31:0] tx_in;

    // Per-byte bit flip so each byte leaves MSB first
    assign tx_in = tx_flip_q ? {ssfa_flip_bytes16(tx_fabric_data[31:16]),
                                ssfa_flip_bytes16(tx_fabric_data[15:0])}
                             : tx_fabric_data;

    ssfa_byte_ser u_ser (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .mode         (mode_q),
        .fabric_data  (tx_in),
        .fabric_ready (tx_fabric_ready),
        .lane_data    (tx_lane_data)
    );

    // =====================================================================
    // Assertions
    // =====================================================================
    property p_sync_drop;
        @(posedge mclk) disable iff (!rst_n)
        !align_en_q |=> !sync_q;
    endproperty
    a_sync_drop: assert property (p_sync_drop)
        else $error("sync held while alignment disabled");

    property p_sync_cause;
        @(posedge mclk) disable iff (!rst_n)
        $rose(sync_q) |-> $past(match) && $past(align_en_q);
    endproperty
    a_sync_cause: assert property (p_sync_cause)
        else $error("sync rose without a pattern match");

    property p_oc96_size;
        @(posedge mclk) disable iff (!rst_n)
        mode_q == SSFA_OC96 |-> use32;
    endproperty
    a_oc96_size: assert property (p_oc96_size)
        else $error("OC-96 not using four-byte pattern");

    property p_tx_cadence;
        @(posedge mclk) disable iff (!rst_n)
        (mode_q != SSFA_OC12) && tx_fabric_ready && !(wr_en && paddr == CTRL_OFFSET)
        |=> !tx_fabric_ready;
    endproperty
    a_tx_cadence: assert property (p_tx_cadence)
        else $error("serializer took words at full rate");

    property p_oc12_bypass;
        @(posedge mclk) disable iff (!rst_n)
        mode_q == SSFA_OC12 ##1 mode_q == SSFA_OC12 |-> rx_fabric_valid && tx_fabric_ready;
    endproperty
    a_oc12_bypass: assert property (p_oc12_bypass)
        else $error("OC-12 path not bypassing byte stages");

    property p_arm_on_rise;
        @(posedge mclk) disable iff (!rst_n)
        sync_rise && mode_q == SSFA_OC48 |=> pend_q;
    endproperty
    a_arm_on_rise: assert property (p_arm_on_rise)
        else $error("ordering check not armed on sync edge");

    property p_insert_cause;
        @(posedge mclk) disable iff (!rst_n)
        insert_q |-> $past(mismatch) && $past(mode_q) == SSFA_OC48;
    endproperty
    a_insert_cause: assert property (p_insert_cause)
        else $error("pad inserted without a byte mismatch");

    property p_pad_value;
        @(posedge mclk) disable iff (!rst_n)
        insert_q && !pad_ovr_q |-> feed[7:0] == FRAME_FIRST_BYTE;
    endproperty
    a_pad_value: assert property (p_pad_value)
        else $error("pad byte differs from first framing byte");

    property p_one_pad;
        @(posedge mclk) disable iff (!rst_n)
        insert_q |-> !pend_q ##1 !insert_q [*2];
    endproperty
    a_one_pad: assert property (p_one_pad)
        else $error("more than one pad per sync edge");

endmodule // ssfa_top

// ---- verilog/ssfa_pkg.sv ----
// Shared constants, types and helpers for the frame aligner path
package ssfa_pkg;

    // =====================================================================
    // Modes and framing
    // =====================================================================
    typedef enum logic [1:0] {
        SSFA_OC12,
        SSFA_OC48,
        SSFA_OC96
    } ssfa_mode_type;

    localparam logic [7:0]  FRAME_FIRST_BYTE  = 8'hF6;
    localparam logic [7:0]  FRAME_SECOND_BYTE = 8'h28;
    localparam logic [15:0] PATTERN_RESET     = 16'hF628;
    localparam int          LANE_W            = 16;
    localparam int          FABRIC_W          = 32;
    localparam int          HIST_W            = 64;

    // =====================================================================
    // APB register map
    // =====================================================================
    localparam logic [11:0] CTRL_OFFSET    = 12'h000;
    localparam logic [11:0] PATTERN_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET  = 12'h008;

    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_TXFLIP_BIT = 2;
    localparam int CTRL_RXFLIP_BIT = 3;
    localparam int CTRL_AFLIP_BIT  = 4;
    localparam int CTRL_ALIGN_BIT  = 5;
    localparam int CTRL_PADOVR_BIT = 6;
    localparam int CTRL_PAD_LSB    = 8;

    localparam int STAT_SYNC_BIT   = 0;
    localparam int STAT_SHIFT_BIT  = 1;
    localparam int STAT_OFF_LSB    = 2;
    localparam int STAT_PADEV_BIT  = 8;

    localparam ssfa_mode_type MODE_RESET = SSFA_OC48;

    // Reverse the bits of a 16-bit value
    function automatic logic [15:0] ssfa_rev16(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    // Reverse the bits inside each byte of a 16-bit value
    function automatic logic [15:0] ssfa_flip_bytes16(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            r[i]   = v[7-i];
            r[8+i] = v[15-i];
        end
        return r;
    endfunction

endpackage

// ---- verilog/ssfa_byte_ser.sv ----
// Transmit byte serializer: one fabric word into two lane words, or into one in OC-12
`timescale 1ns/1ps
module ssfa_byte_ser (
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire ssfa_pkg::ssfa_mode_type      mode,
    input  wire logic [ssfa_pkg::FABRIC_W-1:0] fabric_data,
    output logic                              fabric_ready,
    output logic [ssfa_pkg::LANE_W-1:0]       lane_data
);
    import ssfa_pkg::*;

    logic                phase_q;
    logic [LANE_W-1:0]   hold_q;
    logic [LANE_W-1:0]   lane_q;

    // Take a new word in the first half; OC-12 takes one every cycle
    assign fabric_ready = (mode == SSFA_OC12) || !phase_q;
    assign lane_data    = lane_q;

    // Half-rate phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= (mode == SSFA_OC12) ? 1'b0 : !phase_q;
        end
    end

    // Low half leaves first, upper half next cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lane_q <= 16'h0000;
            hold_q <= 16'h0000;
        end else if (mode == SSFA_OC12) begin
            lane_q <= {8'h00, fabric_data[7:0]};
        end else if (!phase_q) begin
            if (mode == SSFA_OC96) begin
                lane_q <= fabric_data[15:0];
                hold_q <= fabric_data[31:16];
            end else begin
                lane_q <= {8'h00, fabric_data[7:0]};
                hold_q <= {8'h00, fabric_data[15:8]};
            end
        end else begin
            lane_q <= hold_q;
        end
    end

endmodule // ssfa_byte_ser

// ---- verilog/ssfa_byte_deser.sv ----
// Receive byte deserializer: two lane words into one fabric word, or one into one in OC-12
`timescale 1ns/1ps
module ssfa_byte_deser (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire ssfa_pkg::ssfa_mode_type       mode,
    input  wire logic [ssfa_pkg::LANE_W-1:0]   lane_data,
    output logic [ssfa_pkg::FABRIC_W-1:0]      word_data,
    output logic                               word_valid
);
    import ssfa_pkg::*;

    logic                phase_q;
    logic [LANE_W-1:0]   low_q;
    logic [FABRIC_W-1:0] word_q;
    logic                valid_q;

    assign word_data  = word_q;
    assign word_valid = valid_q;

    // Half-rate phase and first-half capture
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 1'b0;
            low_q   <= 16'h0000;
        end else begin
            phase_q <= (mode == SSFA_OC12) ? 1'b0 : !phase_q;
            low_q   <= phase_q ? low_q : lane_data;
        end
    end

    // First lane word lands in the low half of the fabric word
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            word_q  <= 32'h0000_0000;
            valid_q <= 1'b0;
        end else if (mode == SSFA_OC12) begin
            word_q  <= {24'h00_0000, lane_data[7:0]};
            valid_q <= 1'b1;
        end else if (phase_q) begin
            if (mode == SSFA_OC96) begin
                word_q <= {lane_data, low_q};
            end else begin
                word_q <= {16'h0000, lane_data[7:0], low_q[7:0]};
            end
            valid_q <= 1'b1;
        end else begin
            valid_q <= 1'b0;
        end
    end

endmodule // ssfa_byte_deser

// ---- tb/ssfa_fabric_model.sv ----
// Fabric-side user logic model for the frame aligner path
`timescale 1ns/1ps
module ssfa_fabric_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        tx_fabric_ready,
    input  wire logic        size_req,
    output logic [31:0]      tx_fabric_data,
    output logic             align_pattern_size_select,
    output logic             took,
    output logic [31:0]      took_word
);
    integer seed = 91161;

    // ==================================================
    // Transmit feed
    // ==================================================
    // A fresh random word follows every word the block accepts
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_fabric_data <= 32'h0000_0000;
            took           <= 1'b0;
            took_word      <= 32'h0000_0000;
        end else begin
            took <= tx_fabric_ready;
            if (tx_fabric_ready) begin
                took_word      <= tx_fabric_data;
                tx_fabric_data <= $random(seed);
            end
        end
    end

    // Pattern size is a plain level from the fabric
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            align_pattern_size_select <= 1'b0;
        end else begin
            align_pattern_size_select <= size_req;
        end
    end
endmodule // ssfa_fabric_model

// ---- tb/ssfa_top_bench.sv ----
// Self-checking bench for the frame aligner path
`timescale 1ns/1ps
module ssfa_top_bench;
    import ssfa_pkg::*;
    logic          mclk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic          size_req, took, rx_fabric_valid, rx_sync_status;
    logic          tx_fabric_ready, align_pattern_size_select;
    logic          tx_chk, sync_prev, armed, exp_pad, err, half;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rx_fabric_data, tx_fabric_data, took_word, rd;
    logic [15:0]   rx_lane_data, tx_lane_data, m16;
    logic [7:0]    lo;
    ssfa_mode_type mode;
    logic [15:0]   exp_q[$];
    int            fails, n_checks;

    ssfa_top dut_u (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .align_pattern_size_select, .rx_lane_data,
        .rx_fabric_data, .rx_fabric_valid, .rx_sync_status, .tx_fabric_data,
        .tx_fabric_ready, .tx_lane_data);
    ssfa_fabric_model fab_u (.mclk, .rst_n, .tx_fabric_ready, .size_req,
        .tx_fabric_data, .align_pattern_size_select, .took, .took_word);

    // ==================================================
    // Helpers
    // ==================================================
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic logic [7:0] rev8(input logic [7:0] b);
        return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // Mode change with transmit checking paused until the lane settles
    task automatic set_ctrl(input ssfa_mode_type m, input logic en);
        tx_chk = 1'b0;
        repeat (3) @(posedge mclk);
        mode = m;
        apb(1'b1, CTRL_OFFSET, 32'h0000_F61C | 32'(m) | (en ? 32'h0000_0020 : 32'h0000_0000));
        repeat (3) @(posedge mclk);
        tx_chk = 1'b1;
    endtask

    // Far-end byte on the lane, MSB first, earliest bit in bit 0
    task automatic put(input logic [7:0] b);
        if (mode == SSFA_OC96 && !half) begin
            lo = rev8(b);
            half = 1'b1;
        end else begin
            rx_lane_data <= (mode == SSFA_OC96) ? {rev8(b), lo} : {8'h00, rev8(b)};
            half = 1'b0;
            @(posedge mclk);
        end
    endtask

    task automatic rx_case(input ssfa_mode_type m, input logic s, alt, en, e);
        int n;
        logic [31:0] x;
        n = (m == SSFA_OC12) ? 12 : 48;
        set_ctrl(m, 1'b0);
        apb(1'b1, STATUS_OFFSET, 32'h0000_0100);
        size_req <= s;
        exp_pad = 1'b0;
        set_ctrl(m, en);
        for (int i = 0; i < 2 * n; i++)
            put((alt ? i % 2 == 1 : i >= n) ? 8'h28 : 8'hF6);
        x = (m == SSFA_OC12) ? 32'h0000_0028 : (m == SSFA_OC48) ? 32'h0000_2828 : 32'h2828_2828;
        if (!alt && e) check(rx_fabric_data, x);
        repeat (24) put(8'h00);
        check(32'(rx_sync_status), 32'(e));
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        check(32'({rd[8], rd[0]}), 32'({exp_pad, e}));
        apb(1'b1, STATUS_OFFSET, 32'h0000_0100);
        repeat (16) put(8'h00);
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        check(32'(rd[8]), 32'h0000_0000);
    endtask

    // ==================================================
    // Transmit scoreboard
    // ==================================================
    // Note the lane words due for each word the fabric handed over
    always @(negedge mclk) if (tx_chk && took) begin
        if (mode == SSFA_OC96) begin
            exp_q.push_back({rev8(took_word[15:8]), rev8(took_word[7:0])});
            exp_q.push_back({rev8(took_word[31:24]), rev8(took_word[23:16])});
        end else begin
            exp_q.push_back({8'h00, rev8(took_word[7:0])});
            if (mode == SSFA_OC48) exp_q.push_back({8'h00, rev8(took_word[15:8])});
        end
    end

    // Compare each lane word with the oldest note
    always @(posedge mclk) if (exp_q.size() > 0) begin
        m16 = (mode == SSFA_OC96) ? 16'hFFFF : 16'h00FF;
        check({16'h0000, tx_lane_data & m16}, {16'h0000, exp_q.pop_front() & m16});
    end

    // Work out whether a pad is due from the first word after lock
    always @(posedge mclk) begin
        sync_prev <= rx_sync_status;
        if (rx_sync_status && !sync_prev && mode == SSFA_OC48) armed <= 1'b1;
        else if (armed && rx_fabric_valid) begin
            armed   <= 1'b0;
            exp_pad <= (rx_fabric_data[7:0] !== 8'h28);
        end
    end

    // ==================================================
    // Main sequence
    // ==================================================
    initial begin
        {rst_n, psel, penable, pwrite, size_req, tx_chk} = 6'b00_0000;
        {sync_prev, armed, exp_pad, half, fails, n_checks} = '0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        rx_lane_data = 16'h0000;
        mode = SSFA_OC48;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        apb(1'b0, CTRL_OFFSET, 32'h0000_0000);
        check(rd, 32'h0000_F61D);
        apb(1'b0, PATTERN_OFFSET, 32'h0000_0000);
        check(rd, 32'h0000_F628);
        apb(1'b0, 12'hFFC, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        tx_chk = 1'b1;
        rx_case(SSFA_OC48, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_case(SSFA_OC48, 1'b1, 1'b1, 1'b1, 1'b0);
        rx_case(SSFA_OC48, 1'b0, 1'b1, 1'b1, 1'b1);
        rx_case(SSFA_OC48, 1'b1, 1'b0, 1'b1, 1'b1);
        rx_case(SSFA_OC12, 1'b0, 1'b0, 1'b1, 1'b1);
        rx_case(SSFA_OC96, 1'b0, 1'b1, 1'b1, 1'b0);
        rx_case(SSFA_OC96, 1'b0, 1'b0, 1'b1, 1'b1);
        repeat (8) @(posedge mclk);
        final_report();
    end

    // Cut a hung run short
    initial begin
        #(25 * 60000);
        fails++;
        final_report();
    end
endmodule // ssfa_top_bench
